/* dv/ldst_arith_datapath_chk.sv */
// Concurrent checks on the execution datapath ports
`timescale 1ns/10ps
module ldst_arith_datapath_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic start_i,
  input wire dp_pkg::op_t op_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic store_ovf_o,
  input wire logic div_fault_o,
  input wire logic cc_we_o,
  input wire logic rf_we_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_addr_o,
  input wire logic [3:0] mem_be_o
);
  // ========
  // Accepted command, for later cycles
  dp_pkg::op_t op_q;
  logic take;
  assign take = start_i && !busy_o;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) op_q <= dp_pkg::OP_READ_WORD;
    else if (take) op_q <= op_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ========
  // Timing, side effects and byte lanes
  add_timing_a: assert property (take && op_i == dp_pkg::OP_ADD_ORD |-> ##5 done_o && rf_we_o)
    else $error("add late");
  emul_timing_a: assert property (take && op_i == dp_pkg::OP_EXT_MUL |-> ##6 done_o)
    else $error("emul late");
  arith_no_mem_a: assert property (
    take && op_i inside {[dp_pkg::OP_ADD_INT:dp_pkg::OP_MOD_INT]} |-> ##1 (!mem_req_o) [*5])
    else $error("arith mem req");
  move_no_mem_a: assert property (
    take && op_i inside {[dp_pkg::OP_MOV:dp_pkg::OP_ADDR]} |-> ##1 (!mem_req_o) [*3])
    else $error("move mem req");
  ovf_source_a: assert property (
    store_ovf_o |-> op_q inside {dp_pkg::OP_WRITE_BYTE_INT, dp_pkg::OP_WRITE_SHORT_INT})
    else $error("stray ovf");
  cc_source_a: assert property (cc_we_o |-> op_q inside {dp_pkg::OP_ADD_CARRY, dp_pkg::OP_SUB_CARRY})
    else $error("stray cc write");
  fault_no_write_a: assert property (div_fault_o |-> !rf_we_o ##1 !rf_we_o)
    else $error("write on fault");
  byte_lane_a: assert property (
    mem_req_o && op_q inside {dp_pkg::OP_WRITE_BYTE_ORD, dp_pkg::OP_WRITE_BYTE_INT}
    |-> mem_be_o == 4'h1 << mem_addr_o[1:0])
    else $error("byte lane");
  short_lane_a: assert property (
    mem_req_o && op_q inside {dp_pkg::OP_WRITE_SHORT_ORD, dp_pkg::OP_WRITE_SHORT_INT}
    |-> mem_be_o == (mem_addr_o[1] ? 4'hC : 4'h3))
    else $error("short lanes");
  word_lane_a: assert property (
    mem_req_o && op_q inside {dp_pkg::OP_WRITE_WORD, [dp_pkg::OP_WRITE_LONG:dp_pkg::OP_WRITE_QUAD]}
    |-> mem_be_o == 4'hF)
    else $error("word lanes");
  req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("req not held");
  cover property (store_ovf_o);
  cover property (div_fault_o);
  cover property (cc_we_o);
endmodule // ldst_arith_datapath_chk

bind ldst_arith_datapath ldst_arith_datapath_chk chk_inst (.*);

/* dv/mem_model.sv */
// Behavioural memory on the far side of the datapath bus
`timescale 1ns/10ps
module mem_model (
  // Clock
  input wire logic clk_i,
  // Bus from the datapath
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic ack_o,
  // Wait states before each answer
  input wire logic [1:0] wait_i
);
  logic [31:0] mem [64];
  logic [1:0] cnt;
  initial begin
    rdata_o = 32'h0000_0000;
    ack_o = 1'h0;
    cnt = 2'h0;
  end
  // One answer per request; rdata toggles off the ack so stale data shows
  always @(posedge clk_i) begin
    ack_o <= 1'h0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (cnt == wait_i) begin
        ack_o <= 1'h1;
        cnt <= 2'h0;
        if (!we_i) rdata_o <= mem[addr_i[7:2]];
        for (int i = 0; i < 4; i++) begin
          if (we_i && be_i[i]) mem[addr_i[7:2]][8*i+:8] <= wdata_i[8*i+:8];
        end
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule // mem_model

/* dv/tb_load_store_int_arith_datapath.sv */
// Self-checking bench for the load/store and integer arithmetic datapath
`timescale 1ns/10ps
module tb_load_store_int_arith_datapath;
  // ========
  // Signals, register file and bookkeeping
  logic clk_i, reset_i, start_i, busy_o, done_o, store_ovf_o, div_fault_o, cc_we_o;
  logic rf_we_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [1:0] wait_st;
  logic [2:0] cc_i, cc_o, cc_seen;
  logic [3:0] mem_be_o;
  logic [4:0] dst_i, src_a_i, src_b_i, rf_raddr_o, rf_waddr_o;
  logic [31:0] addr_i, rf_rdata_i, rf_wdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [31:0] rf [32];
  dp_pkg::op_t op_i;
  int n_errors, check_count, n_ovf, n_fault;

  ldst_arith_datapath ldst_arith_datapath_inst (.*);
  mem_model mem_model_inst (.clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .be_i(mem_be_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i), .wait_i(wait_st));

  // Free-running 125 MHz clock
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  // Async-read register file; event pulses counted
  assign rf_rdata_i = rf[rf_raddr_o];
  always @(posedge clk_i) begin
    if (rf_we_o) rf[rf_waddr_o] <= rf_wdata_o;
    if (store_ovf_o) n_ovf++;
    if (div_fault_o) n_fault++;
    if (cc_we_o) cc_seen <= cc_o;
  end

  // ========
  // Shared tasks
  task automatic check(input string what, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One command; wait for done, let last write land
  task automatic run(input dp_pkg::op_t op, input logic [4:0] d, a, b, input logic [31:0] ea);
    int i;
    n_ovf = 0;
    n_fault = 0;
    op_i = op;
    dst_i = d;
    src_a_i = a;
    src_b_i = b;
    addr_i = ea;
    start_i = 1'h1;
    @(negedge clk_i);
    start_i = 1'h0;
    for (i = 0; i < 200 && done_o !== 1'h1; i++)
      @(negedge clk_i);
    if (i == 200) begin
      n_errors++;
      tally_and_finish();
    end
    @(negedge clk_i);
  endtask
  task automatic ld_one(input dp_pkg::op_t op, input logic [31:0] ea, exp);
    rf[3] = 32'h5555_5555;
    run(op, 5'h03, 5'h00, 5'h00, ea);
    check("load", rf[3], exp);
  endtask
  task automatic st_one(input dp_pkg::op_t op, input logic [31:0] v, ea, exp, input int ovf);
    rf[5] = v;
    mem_model_inst.mem[12] = 32'hAAAA_AAAA;
    run(op, 5'h05, 5'h00, 5'h00, ea);
    check("store", mem_model_inst.mem[12], exp);
    check("ovf", n_ovf, ovf);
  endtask
  // Operand a in r1, b in r2, result in r4 and r5
  task automatic ar(input dp_pkg::op_t op, input logic [31:0] a, b, exp);
    rf[1] = a;
    rf[2] = b;
    rf[4] = 32'h5555_5555;
    rf[5] = 32'h6666_6666;
    run(op, 5'h04, 5'h01, 5'h02, 32'h0000_0040);
    check("result", rf[4], exp);
  endtask
  task automatic ac(input dp_pkg::op_t op, input logic [31:0] a, b, exp, input logic [2:0] cc, ccx);
    cc_i = cc;
    cc_seen = 3'hx;
    ar(op, a, b, exp);
    check("cc", cc_seen, ccx);
  endtask

  // ========
  // Scenarios
  task automatic t_load;
    wait_st = 2'h1;
    mem_model_inst.mem[4] = 32'h8081_F27F;
    ld_one(dp_pkg::OP_READ_WORD, 32'h0000_0010, 32'h8081_F27F);
    ld_one(dp_pkg::OP_READ_BYTE_ORD, 32'h0000_0011, 32'h0000_00F2);
    ld_one(dp_pkg::OP_READ_SHORT_ORD, 32'h0000_0012, 32'h0000_8081);
    ld_one(dp_pkg::OP_READ_BYTE_INT, 32'h0000_0011, 32'hFFFF_FFF2);
    ld_one(dp_pkg::OP_READ_BYTE_INT, 32'h0000_0010, 32'h0000_007F);
    ld_one(dp_pkg::OP_READ_SHORT_INT, 32'h0000_0010, 32'hFFFF_F27F);
    $display("load test done");
  endtask
  // Slow memory: requests held on every word
  task automatic t_multi;
    wait_st = 2'h3;
    for (int j = 0; j < 3; j++) begin
      for (int k = 0; k < 5; k++) begin
        rf[8 + k] = 32'h0000_0000;
        mem_model_inst.mem[16 + k] = 32'h0000_0000;
        mem_model_inst.mem[8 + k] = 32'h1111_1111 * (k + 1) + j;
      end
      run(dp_pkg::op_t'(dp_pkg::OP_READ_LONG + j), 5'h08, 5'h00, 5'h00, 32'h0000_0020);
      run(dp_pkg::op_t'(dp_pkg::OP_WRITE_LONG + j), 5'h08, 5'h00, 5'h00, 32'h0000_0040);
      for (int k = 0; k < 5; k++) begin
        check("load grp", rf[8 + k], k < j + 2 ? mem_model_inst.mem[8 + k] : 32'h0000_0000);
        check("store grp", mem_model_inst.mem[16 + k], k < j + 2 ? rf[8 + k] : 32'h0000_0000);
      end
    end
    $display("multiword test done");
  endtask
  task automatic t_store;
    wait_st = 2'h0;
    st_one(dp_pkg::OP_WRITE_WORD, 32'h1234_5678, 32'h0000_0030, 32'h1234_5678, 0);
    st_one(dp_pkg::OP_WRITE_BYTE_ORD, 32'h1234_5680, 32'h0000_0031, 32'hAAAA_80AA, 0);
    st_one(dp_pkg::OP_WRITE_BYTE_INT, 32'hFFFF_FF80, 32'h0000_0033, 32'h80AA_AAAA, 0);
    st_one(dp_pkg::OP_WRITE_BYTE_INT, 32'h0000_0180, 32'h0000_0030, 32'hAAAA_AA80, 1);
    st_one(dp_pkg::OP_WRITE_SHORT_ORD, 32'h0001_8000, 32'h0000_0032, 32'h8000_AAAA, 0);
    st_one(dp_pkg::OP_WRITE_SHORT_INT, 32'h0000_8000, 32'h0000_0030, 32'hAAAA_8000, 1);
    st_one(dp_pkg::OP_WRITE_SHORT_INT, 32'hFFFF_8000, 32'h0000_0032, 32'h8000_AAAA, 0);
    $display("store test done");
  endtask
  task automatic t_move;
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 5; k++) begin
        rf[16 + k] = 32'h0000_0000;
        rf[8 + k] = 32'h0A0B_0000 + k;
      end
      run(dp_pkg::op_t'(dp_pkg::OP_MOV + j), 5'h10, 5'h08, 5'h00, 32'h0000_0020);
      for (int k = 0; k < 5; k++)
        check("move", rf[16 + k], k <= j ? rf[8 + k] : 32'h0000_0000);
    end
    run(dp_pkg::OP_ADDR, 5'h14, 5'h00, 5'h00, 32'h1234_5678);
    check("addr", rf[20], 32'h1234_5678);
    $display("move test done");
  endtask
  task automatic t_arith;
    ar(dp_pkg::OP_ADD_ORD, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0000);
    ar(dp_pkg::OP_ADD_INT, 32'h0000_0003, 32'hFFFF_FFF9, 32'hFFFF_FFFC);
    ar(dp_pkg::OP_SUB_ORD, 32'h0000_0005, 32'h0000_0003, 32'hFFFF_FFFE);
    ar(dp_pkg::OP_SUB_INT, 32'hFFFF_FFFE, 32'h0000_0007, 32'h0000_0009);
    ar(dp_pkg::OP_MUL_ORD, 32'h0001_0000, 32'h0001_0003, 32'h0003_0000);
    ar(dp_pkg::OP_MUL_INT, 32'hFFFF_FFFD, 32'h0000_0005, 32'hFFFF_FFF1);
    ar(dp_pkg::OP_DIV_ORD, 32'h0000_0007, 32'hFFFF_FFFF, 32'h2492_4924);
    ar(dp_pkg::OP_DIV_INT, 32'h0000_0002, 32'hFFFF_FFF9, 32'hFFFF_FFFD);
    ar(dp_pkg::OP_REM_ORD, 32'h0000_0007, 32'hFFFF_FFFF, 32'h0000_0003);
    ar(dp_pkg::OP_REM_INT, 32'h0000_0002, 32'hFFFF_FFF9, 32'hFFFF_FFFF);
    ar(dp_pkg::OP_MOD_INT, 32'h0000_0002, 32'hFFFF_FFF9, 32'h0000_0001);
    ar(dp_pkg::OP_MOD_INT, 32'hFFFF_FFFE, 32'h0000_0007, 32'hFFFF_FFFF);
    ac(dp_pkg::OP_ADD_CARRY, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0001, 3'h2, 3'h2);
    ac(dp_pkg::OP_ADD_CARRY, 32'h7FFF_FFFF, 32'h0000_0000, 32'h8000_0000, 3'h6, 3'h5);
    ac(dp_pkg::OP_SUB_CARRY, 32'h0000_0001, 32'h0000_0000, 32'hFFFF_FFFE, 3'h0, 3'h0);
    ac(dp_pkg::OP_SUB_CARRY, 32'h0000_0001, 32'h8000_0000, 32'h7FFF_FFFF, 3'h2, 3'h3);
    ar(dp_pkg::OP_EXT_MUL, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0001);
    check("prod hi", rf[5], 32'hFFFF_FFFE);
    rf[3] = 32'h0000_0001;
    ar(dp_pkg::OP_EXT_DIV, 32'h0000_0010, 32'h0000_0005, 32'h0000_0005);
    check("quotient", rf[5], 32'h1000_0000);
    $display("arithmetic test done");
  endtask
  task automatic t_fault;
    dp_pkg::op_t fo [6] = '{dp_pkg::OP_DIV_INT, dp_pkg::OP_DIV_ORD, dp_pkg::OP_REM_INT, dp_pkg::OP_REM_ORD,
      dp_pkg::OP_MOD_INT, dp_pkg::OP_EXT_DIV};
    for (int j = 0; j < 6; j++) begin
      ar(fo[j], 32'h0000_0000, 32'h0000_0009, 32'h5555_5555);
      check("faults", n_fault, 1);
      check("reg pair", rf[5], 32'h6666_6666);
    end
    $display("zero divisor test done");
  endtask

  // Reset for eight cycles, then every scenario in turn
  initial begin
    reset_i = 1'h1;
    start_i = 1'h0;
    op_i = dp_pkg::OP_READ_WORD;
    cc_i = 3'h0;
    wait_st = 2'h0;
    for (int k = 0; k < 32; k++)
      rf[k] = 32'h0000_0000;
    repeat (8) @(negedge clk_i);
    reset_i = 1'h0;
    t_load();
    t_multi();
    t_store();
    t_move();
    t_arith();
    t_fault();
    tally_and_finish();
  end
endmodule // tb_load_store_int_arith_datapath

/* logic/div_unit.sv */
// Unsigned 64-by-32 restoring divider, one quotient bit per cycle
`timescale 1ns/10ps
module div_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Request
  input wire logic start_i,
  input wire logic [63:0] dividend_i,
  input wire logic [31:0] divisor_i,
  // Result
  output logic done_o,
  output logic [63:0] quotient_o,
  output logic [31:0] remainder_o
);

  logic [6:0] count;
  logic busy;
  logic [31:0] divisor;
  logic [32:0] shifted;

  // Partial remainder with the next dividend bit brought down
  assign shifted = {remainder_o, quotient_o[63]};

  // ==========================================================
  // Iteration; divisor is never zero here, the caller faults first
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      busy <= 1'b0;
      count <= 7'h00;
      divisor <= 32'h0000_0000;
      quotient_o <= 64'h0000_0000_0000_0000;
      remainder_o <= 32'h0000_0000;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy <= 1'b1;
        count <= dp_pkg::DIV_STEPS;
        divisor <= divisor_i;
        quotient_o <= dividend_i;
        remainder_o <= 32'h0000_0000;
      end else if (busy) begin
        if (shifted >= {1'b0, divisor}) begin
          remainder_o <= 32'(shifted - {1'b0, divisor});
          quotient_o <= {quotient_o[62:0], 1'b1};
        end else begin
          remainder_o <= shifted[31:0];
          quotient_o <= {quotient_o[62:0], 1'b0};
        end
        count <= count - 7'h01;
        if (count == 7'h01) begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule // div_unit

/* logic/dp_pkg.sv */
// Shared types and constants for the load/store and integer arithmetic datapath
package dp_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned REG_AW = 5;

  // ==========================================================
  // Condition code layout (three bits)
  localparam int unsigned CC_W = 3;
  localparam int unsigned CC_CARRY_BIT = 1;
  localparam int unsigned CC_OVF_BIT = 0;
  localparam logic [2:0] CC_RESET = 3'h0;

  // ==========================================================
  // Divider step count and byte step between memory words
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

  // ==========================================================
  // Operations accepted on the command port
  typedef enum logic [5:0] {
    OP_READ_WORD, OP_READ_BYTE_ORD, OP_READ_SHORT_ORD, OP_READ_BYTE_INT, OP_READ_SHORT_INT,
    OP_READ_LONG, OP_READ_TRIPLE, OP_READ_QUAD,
    OP_WRITE_WORD, OP_WRITE_BYTE_ORD, OP_WRITE_SHORT_ORD, OP_WRITE_BYTE_INT, OP_WRITE_SHORT_INT,
    OP_WRITE_LONG, OP_WRITE_TRIPLE, OP_WRITE_QUAD,
    OP_MOV, OP_MOV_LONG, OP_MOV_TRIPLE, OP_MOV_QUAD, OP_ADDR,
    OP_ADD_INT, OP_ADD_ORD, OP_SUB_INT, OP_SUB_ORD, OP_MUL_INT, OP_MUL_ORD,
    OP_DIV_INT, OP_DIV_ORD, OP_ADD_CARRY, OP_SUB_CARRY, OP_EXT_MUL, OP_EXT_DIV,
    OP_REM_INT, OP_REM_ORD, OP_MOD_INT
  } op_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_A, ST_RD_B, ST_RD_C, ST_EXEC, ST_DIV_WAIT, ST_WR, ST_SETUP, ST_MEM, ST_DONE
  } state_t;

endpackage

/* logic/ldst_arith_datapath.sv */
// Load, store, move, address and integer/ordinal arithmetic execution datapath
// Functional notes
// - Single-register loads copy memory word into destination
// - Narrow loads widen automatically to register width
// - Multiword loads fill consecutive registers from memory
// - Byte and short stores narrow register value
// - Integer narrow stores flag unrepresentable values
// - Multiword stores write consecutive registers to memory
// - Moves copy register groups, never touch memory
// - Address operation writes address, no memory access
// - Arithmetic operands come only from registers
// - Word add/sub/mul/div write single-word result
// - Carry ops use and set carry bit
// - Carry ops also flag signed overflow bit
// - Extended multiply writes 64-bit product pair
// - Extended divide gives quotient and remainder
// - Remainder takes the sign of the dividend
// - Modulo takes the sign of the divisor
`timescale 1ns/10ps
module ldst_arith_datapath (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Command port
  input wire logic start_i,
  input wire dp_pkg::op_t op_i,
  input wire logic [4:0] dst_i,
  input wire logic [4:0] src_a_i,
  input wire logic [4:0] src_b_i,
  input wire logic [31:0] addr_i,
  input wire logic [2:0] cc_i,
  output logic busy_o,
  output logic done_o,
  // Events
  output logic store_ovf_o,
  output logic div_fault_o,
  // Condition code update
  output logic cc_we_o,
  output logic [2:0] cc_o,
  // Register file
  output logic [4:0] rf_raddr_o,
  input wire logic [31:0] rf_rdata_i,
  output logic rf_we_o,
  output logic [4:0] rf_waddr_o,
  output logic [31:0] rf_wdata_o,
  // Memory bus
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [3:0] mem_be_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i
);

  dp_pkg::state_t state;
  dp_pkg::op_t op;
  logic [4:0] dst;
  logic [4:0] src_a;
  logic [4:0] src_b;
  logic [31:0] ea;
  logic [2:0] cc_in;
  logic [1:0] cnt;
  logic [1:0] last;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] opc;
  logic [63:0] res;
  logic div_start;
  logic div_done;
  logic [63:0] div_quo;
  logic [31:0] div_rem;
  logic [63:0] dividend;
  logic [31:0] divisor;

  // ==========================================================
  // Decoding helpers, shared by several processes
  function automatic logic [1:0] words_less_one(input dp_pkg::op_t o);
    unique case (o)
      dp_pkg::OP_READ_LONG, dp_pkg::OP_WRITE_LONG, dp_pkg::OP_MOV_LONG: words_less_one = 2'd1;
      dp_pkg::OP_READ_TRIPLE, dp_pkg::OP_WRITE_TRIPLE, dp_pkg::OP_MOV_TRIPLE: words_less_one = 2'd2;
      dp_pkg::OP_READ_QUAD, dp_pkg::OP_WRITE_QUAD, dp_pkg::OP_MOV_QUAD: words_less_one = 2'd3;
      default: words_less_one = 2'd0;
    endcase
  endfunction

  function automatic logic is_load(input dp_pkg::op_t o);
    is_load = (o <= dp_pkg::OP_READ_QUAD);
  endfunction

  function automatic logic is_store(input dp_pkg::op_t o);
    is_store = (o >= dp_pkg::OP_WRITE_WORD) && (o <= dp_pkg::OP_WRITE_QUAD);
  endfunction

  function automatic logic is_div(input dp_pkg::op_t o);
    is_div = (o == dp_pkg::OP_DIV_INT) || (o == dp_pkg::OP_DIV_ORD) || (o == dp_pkg::OP_EXT_DIV) ||
             (o == dp_pkg::OP_REM_INT) || (o == dp_pkg::OP_REM_ORD) || (o == dp_pkg::OP_MOD_INT);
  endfunction

  function automatic logic is_signed_div(input dp_pkg::op_t o);
    is_signed_div = (o == dp_pkg::OP_DIV_INT) || (o == dp_pkg::OP_REM_INT) || (o == dp_pkg::OP_MOD_INT);
  endfunction

  // Pick the addressed lane and widen it; the lane comes from the low address bits
  function automatic logic [31:0] load_extend(input dp_pkg::op_t o, input logic [31:0] w, input logic [1:0] a);
    logic [7:0] b;
    logic [15:0] h;
    b = w[8*a +: 8];
    h = a[1] ? w[31:16] : w[15:0];
    unique case (o)
      dp_pkg::OP_READ_BYTE_ORD: load_extend = {24'h00_0000, b};
      dp_pkg::OP_READ_SHORT_ORD: load_extend = {16'h0000, h};
      dp_pkg::OP_READ_BYTE_INT: load_extend = {{24{b[7]}}, b};
      dp_pkg::OP_READ_SHORT_INT: load_extend = {{16{h[15]}}, h};
      default: load_extend = w;
    endcase
  endfunction

  // ==========================================================
  // Handshake and register read address, decoded from the state
  assign busy_o = (state != dp_pkg::ST_IDLE);
  assign done_o = (state == dp_pkg::ST_DONE);
  assign mem_req_o = (state == dp_pkg::ST_MEM);
  always_comb begin
    unique case (state)
      dp_pkg::ST_RD_A: rf_raddr_o = src_a;
      dp_pkg::ST_RD_B: rf_raddr_o = src_b;
      dp_pkg::ST_RD_C: rf_raddr_o = 5'(src_b + 5'd1);
      dp_pkg::ST_SETUP: rf_raddr_o = 5'((is_store(op) ? dst : src_a) + {3'b000, cnt});
      default: rf_raddr_o = src_a;
    endcase
  end

  // ==========================================================
  // Divider operands: magnitudes for signed forms, pair for extended divide
  always_comb begin
    divisor = (is_signed_div(op) && opa[31]) ? 32'(-opa) : opa;
    if (op == dp_pkg::OP_EXT_DIV) begin
      dividend = {opc, opb};
    end else if (is_signed_div(op) && opb[31]) begin
      dividend = {32'h0000_0000, 32'(-opb)};
    end else begin
      dividend = {32'h0000_0000, opb};
    end
  end

  div_unit u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(div_start),
    .dividend_i(dividend),
    .divisor_i(divisor),
    .done_o(div_done),
    .quotient_o(div_quo),
    .remainder_o(div_rem)
  );

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= dp_pkg::ST_IDLE;
      op <= dp_pkg::OP_READ_WORD;
      dst <= 5'h00;
      src_a <= 5'h00;
      src_b <= 5'h00;
      ea <= 32'h0000_0000;
      cc_in <= dp_pkg::CC_RESET;
      cnt <= 2'd0;
      last <= 2'd0;
    end else begin
      unique case (state)
        dp_pkg::ST_IDLE: if (start_i) begin
          op <= op_i;
          dst <= dst_i;
          src_a <= src_a_i;
          src_b <= src_b_i;
          ea <= addr_i;
          cc_in <= cc_i;
          cnt <= 2'd0;
          last <= words_less_one(op_i);
          state <= (op_i >= dp_pkg::OP_ADD_INT) ? dp_pkg::ST_RD_A : dp_pkg::ST_SETUP;
        end
        dp_pkg::ST_RD_A: state <= dp_pkg::ST_RD_B;
        dp_pkg::ST_RD_B: state <= (op == dp_pkg::OP_EXT_DIV) ? dp_pkg::ST_RD_C : dp_pkg::ST_EXEC;
        dp_pkg::ST_RD_C: state <= dp_pkg::ST_EXEC;
        dp_pkg::ST_EXEC: begin
          last <= (op == dp_pkg::OP_EXT_MUL || op == dp_pkg::OP_EXT_DIV) ? 2'd1 : 2'd0;
          if (is_div(op)) begin
            state <= (opa == 32'h0000_0000) ? dp_pkg::ST_DONE : dp_pkg::ST_DIV_WAIT;
          end else begin
            state <= dp_pkg::ST_WR;
          end
        end
        dp_pkg::ST_DIV_WAIT: if (div_done) state <= dp_pkg::ST_WR;
        dp_pkg::ST_WR: begin
          cnt <= cnt + 2'd1;
          if (cnt == last) state <= dp_pkg::ST_DONE;
        end
        dp_pkg::ST_SETUP: begin
          if (is_load(op) || is_store(op)) begin
            state <= dp_pkg::ST_MEM;
          end else begin
            cnt <= cnt + 2'd1;
            if (cnt == last) state <= dp_pkg::ST_DONE;
          end
        end
        dp_pkg::ST_MEM: if (mem_ack_i) begin
          cnt <= cnt + 2'd1;
          state <= (cnt == last) ? dp_pkg::ST_DONE : dp_pkg::ST_SETUP;
        end
        dp_pkg::ST_DONE: state <= dp_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Operand capture from the register read port
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      opa <= 32'h0000_0000;
      opb <= 32'h0000_0000;
      opc <= 32'h0000_0000;
    end else begin
      if (state == dp_pkg::ST_RD_A) opa <= rf_rdata_i;
      if (state == dp_pkg::ST_RD_B) opb <= rf_rdata_i;
      if (state == dp_pkg::ST_RD_C) opc <= rf_rdata_i;
    end
  end

  // ==========================================================
  // Arithmetic: result is b op a; carry ops also update the condition code
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      res <= 64'h0000_0000_0000_0000;
      cc_o <= dp_pkg::CC_RESET;
      cc_we_o <= 1'b0;
      div_start <= 1'b0;
      div_fault_o <= 1'b0;
    end else begin
      cc_we_o <= 1'b0;
      div_start <= 1'b0;
      div_fault_o <= 1'b0;
      if (state == dp_pkg::ST_EXEC) begin
        unique case (op)
          dp_pkg::OP_ADD_INT, dp_pkg::OP_ADD_ORD: res <= {32'h0000_0000, 32'(opb + opa)};
          dp_pkg::OP_SUB_INT, dp_pkg::OP_SUB_ORD: res <= {32'h0000_0000, 32'(opb - opa)};
          dp_pkg::OP_MUL_INT: res <= {32'h0000_0000, 32'($signed(opb) * $signed(opa))};
          dp_pkg::OP_MUL_ORD: res <= {32'h0000_0000, 32'(opb * opa)};
          dp_pkg::OP_EXT_MUL: res <= 64'({32'h0000_0000, opb} * {32'h0000_0000, opa});
          dp_pkg::OP_ADD_CARRY, dp_pkg::OP_SUB_CARRY: begin
            // Subtract is b + ~a + carry, so a set carry means no borrow
            logic [31:0] rhs;
            logic [32:0] sum;
            rhs = (op == dp_pkg::OP_SUB_CARRY) ? ~opa : opa;
            sum = {1'b0, opb} + {1'b0, rhs} + {32'h0000_0000, cc_in[dp_pkg::CC_CARRY_BIT]};
            res <= {32'h0000_0000, sum[31:0]};
            cc_we_o <= 1'b1;
            cc_o <= cc_in;
            cc_o[dp_pkg::CC_CARRY_BIT] <= sum[32];
            cc_o[dp_pkg::CC_OVF_BIT] <= (opb[31] == rhs[31]) && (sum[31] != opb[31]);
          end
          default: begin
            div_start <= (opa != 32'h0000_0000);
            div_fault_o <= (opa == 32'h0000_0000);
          end
        endcase
      end else if (div_done) begin
        unique case (op)
          dp_pkg::OP_DIV_INT: res <= {32'h0000_0000, (opa[31] ^ opb[31]) ? 32'(-div_quo[31:0]) : div_quo[31:0]};
          dp_pkg::OP_DIV_ORD: res <= {32'h0000_0000, div_quo[31:0]};
          dp_pkg::OP_EXT_DIV: res <= {div_quo[31:0], div_rem};
          dp_pkg::OP_REM_INT: res <= {32'h0000_0000, opb[31] ? 32'(-div_rem) : div_rem};
          dp_pkg::OP_MOD_INT: begin
            // Truncated remainder first, then pull it onto the divisor's side
            logic [31:0] r;
            r = opb[31] ? 32'(-div_rem) : div_rem;
            res <= {32'h0000_0000, (r != 32'h0000_0000 && (r[31] != opa[31])) ? 32'(r + opa) : r};
          end
          default: res <= {32'h0000_0000, div_rem};
        endcase
      end
    end
  end

  // ==========================================================
  // Memory side: word address steps by four, byte stores drive one lane, short stores two
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_be_o <= 4'h0;
      mem_wdata_o <= 32'h0000_0000;
      store_ovf_o <= 1'b0;
    end else begin
      store_ovf_o <= 1'b0;
      if (state == dp_pkg::ST_SETUP && (is_load(op) || is_store(op))) begin
        mem_we_o <= is_store(op);
        mem_addr_o <= 32'(ea + {28'h000_0000, 2'b00, cnt} * dp_pkg::WORD_BYTES);
        unique case (op)
          dp_pkg::OP_READ_BYTE_ORD, dp_pkg::OP_READ_BYTE_INT,
          dp_pkg::OP_WRITE_BYTE_ORD, dp_pkg::OP_WRITE_BYTE_INT: begin
            mem_be_o <= 4'h1 << ea[1:0];
            mem_wdata_o <= {4{rf_rdata_i[7:0]}};
          end
          dp_pkg::OP_READ_SHORT_ORD, dp_pkg::OP_READ_SHORT_INT,
          dp_pkg::OP_WRITE_SHORT_ORD, dp_pkg::OP_WRITE_SHORT_INT: begin
            mem_be_o <= ea[1] ? 4'hc : 4'h3;
            mem_wdata_o <= {2{rf_rdata_i[15:0]}};
          end
          default: begin
            mem_be_o <= 4'hf;
            mem_wdata_o <= rf_rdata_i;
          end
        endcase
        // Value still written in narrowed form; software sees the event
        if (op == dp_pkg::OP_WRITE_BYTE_INT) store_ovf_o <= (rf_rdata_i[31:7] != {25{rf_rdata_i[7]}});
        if (op == dp_pkg::OP_WRITE_SHORT_INT) store_ovf_o <= (rf_rdata_i[31:15] != {17{rf_rdata_i[15]}});
      end
    end
  end

  // ==========================================================
  // Register file write port
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rf_we_o <= 1'b0;
      rf_waddr_o <= 5'h00;
      rf_wdata_o <= 32'h0000_0000;
    end else begin
      rf_we_o <= 1'b0;
      rf_waddr_o <= 5'(dst + {3'b000, cnt});
      if (state == dp_pkg::ST_MEM && mem_ack_i && is_load(op)) begin
        rf_we_o <= 1'b1;
        rf_wdata_o <= load_extend(op, mem_rdata_i, ea[1:0]);
      end else if (state == dp_pkg::ST_SETUP && op == dp_pkg::OP_ADDR) begin
        rf_we_o <= 1'b1;
        rf_wdata_o <= ea;
      end else if (state == dp_pkg::ST_SETUP && !is_load(op) && !is_store(op)) begin
        rf_we_o <= 1'b1;
        rf_wdata_o <= rf_rdata_i;
      end else if (state == dp_pkg::ST_WR) begin
        rf_we_o <= 1'b1;
        rf_wdata_o <= cnt[0] ? res[63:32] : res[31:0];
      end
    end
  end

endmodule // ldst_arith_datapath
